// file: hw/smm_master.v
`include "smm_defines.vh"
module smm_master #(
    parameter HALF = `SMM_HALF_PERIOD,
    parameter NBITS = `SMM_BITS_PER_BYTE
) (
    // clock and reset
    input wire i_ref_clk,
    input wire i_reset,
    // control writes
    input wire i_ctl_we,
    input wire i_master_enable,
    input wire i_port_enable,
    input wire i_select_mode_high,
    input wire i_select_mode_low,
    input wire i_intr_enable,
    input wire i_done_clr,
    input wire i_fault_clr,
    // data port
    input wire i_data_we,
    input wire [7:0] i_data,
    output reg [7:0] o_rx_data,
    // status
    output reg o_master_enable_flag,
    output reg o_port_enable_bit,
    output reg o_transfer_done_flag,
    output reg o_mode_fault_flag,
    output reg o_tx_buf_full,
    output reg o_busy,
    output reg o_irq,
    // serial pins
    output reg o_sck,
    output reg o_sck_oe,
    output reg o_mosi,
    output reg o_mosi_oe,
    input wire i_miso,
    input wire i_ss,
    output reg o_ss,
    output reg o_ss_oe
);
    //----------------------------------------
    // state
    //----------------------------------------
    localparam ST_IDLE = 1'b0;
    localparam ST_SHIFT = 1'b1;
    localparam NPINS = 2;
    localparam PIN_MISO = 0;
    localparam PIN_SS = 1;

    reg state_r;
    reg state_nxt;
    reg sel_hi_r;
    reg sel_hi_nxt;
    reg sel_lo_r;
    reg sel_lo_nxt;
    reg ien_r;
    reg ien_nxt;
    reg [7:0] txbuf_r;
    reg [7:0] txbuf_nxt;
    reg [7:0] shift_r;
    reg [7:0] shift_nxt;
    reg [3:0] bits_r;
    reg [3:0] bits_nxt;
    // next values of the output flops
    reg master_en_nxt;
    reg port_en_nxt;
    reg fault_flag_nxt;
    reg done_nxt;
    reg irq_nxt;
    reg buf_full_nxt;
    reg busy_nxt;
    reg sck_nxt;
    reg mosi_nxt;
    reg [7:0] rx_nxt;
    reg sck_oe_nxt;
    reg mosi_oe_nxt;
    reg ss_nxt;
    reg ss_oe_nxt;
    wire [NPINS-1:0] pins_async;
    wire [NPINS-1:0] pins_sync;
    wire miso_s;
    wire ss_s;
    wire rise;
    wire fall;
    wire run;
    wire multi = !sel_hi_r && sel_lo_r;
    wire fault = multi && !ss_s && o_master_enable_flag;
    wire enabled = o_master_enable_flag && o_port_enable_bit;
    wire last = (bits_r == NBITS - 1) && fall;
    wire take = i_data_we && enabled;
    wire done_set = (state_r == ST_SHIFT) && last && !fault;

    //----------------------------------------
    // pin synchronisers
    //----------------------------------------
    // both pins come from outside the clock domain
    assign pins_async[PIN_MISO] = i_miso;
    assign pins_async[PIN_SS] = i_ss;
    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi = gi + 1) begin : g_sync
            smm_sync u_smm_sync (
                .i_ref_clk(i_ref_clk),
                .i_reset(i_reset),
                .i_async(pins_async[gi]),
                .o_sync(pins_sync[gi])
            );
        end
    endgenerate
    assign miso_s = pins_sync[PIN_MISO];
    assign ss_s = pins_sync[PIN_SS];

    //----------------------------------------
    // serial clock edges
    //----------------------------------------
    // divider held in reset between bytes, so each byte starts on a full half period
    assign run = (state_r == ST_SHIFT) && !fault;
    smm_clkgen #(
        .HALF(HALF)
    ) u_smm_clkgen (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_run(run),
        .o_rise(rise),
        .o_fall(fall)
    );

    //----------------------------------------
    // control and status
    //----------------------------------------
    always @* begin
        master_en_nxt = o_master_enable_flag;
        port_en_nxt = o_port_enable_bit;
        sel_hi_nxt = sel_hi_r;
        sel_lo_nxt = sel_lo_r;
        ien_nxt = ien_r;
        if (fault) begin
            master_en_nxt = 1'b0;
            port_en_nxt = 1'b0;
        end else if (i_ctl_we) begin
            // never re-enabled by hardware after a fault
            master_en_nxt = i_master_enable;
            port_en_nxt = i_port_enable;
        end
        if (i_ctl_we) begin
            sel_hi_nxt = i_select_mode_high;
            sel_lo_nxt = i_select_mode_low;
            ien_nxt = i_intr_enable;
        end
    end
    // sticky flags: a set in the same cycle as a clear wins
    always @* begin
        fault_flag_nxt = o_mode_fault_flag;
        done_nxt = o_transfer_done_flag;
        if (fault)
            fault_flag_nxt = 1'b1;
        else if (i_fault_clr)
            fault_flag_nxt = 1'b0;
        if (done_set)
            done_nxt = 1'b1;
        else if (i_done_clr)
            done_nxt = 1'b0;
        irq_nxt = ien_r && (done_set || fault);
    end
    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_master_enable_flag <= 1'b0;
            o_port_enable_bit <= 1'b0;
            o_mode_fault_flag <= 1'b0;
            o_transfer_done_flag <= 1'b0;
            sel_hi_r <= `SMM_RST_SEL_HI;
            sel_lo_r <= `SMM_RST_SEL_LO;
            ien_r <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            o_master_enable_flag <= master_en_nxt;
            o_port_enable_bit <= port_en_nxt;
            o_mode_fault_flag <= fault_flag_nxt;
            o_transfer_done_flag <= done_nxt;
            sel_hi_r <= sel_hi_nxt;
            sel_lo_r <= sel_lo_nxt;
            ien_r <= ien_nxt;
            o_irq <= irq_nxt;
        end
    end

    //----------------------------------------
    // transfer engine
    //----------------------------------------
    always @* begin
        state_nxt = state_r;
        txbuf_nxt = txbuf_r;
        buf_full_nxt = o_tx_buf_full;
        shift_nxt = shift_r;
        bits_nxt = bits_r;
        rx_nxt = o_rx_data;
        busy_nxt = o_busy;
        sck_nxt = o_sck;
        mosi_nxt = o_mosi;
        if (take) begin
            txbuf_nxt = i_data;
            buf_full_nxt = 1'b1;
        end
        case (state_r)
            ST_IDLE: begin
                sck_nxt = 1'b0;
                // a write in this same cycle waits a clock so its byte is the one sent
                if (o_tx_buf_full && enabled && !fault && !take) begin
                    shift_nxt = txbuf_r;
                    mosi_nxt = txbuf_r[7];
                    buf_full_nxt = 1'b0;
                    bits_nxt = 4'h0;
                    busy_nxt = 1'b1;
                    state_nxt = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (fault || !enabled) begin
                    // abandon the byte and drop anything queued behind it
                    state_nxt = ST_IDLE;
                    busy_nxt = 1'b0;
                    sck_nxt = 1'b0;
                    buf_full_nxt = 1'b0;
                end else if (rise) begin
                    // sample on the rising edge, shift out on the falling edge
                    sck_nxt = 1'b1;
                    shift_nxt = {shift_r[6:0], miso_s};
                end else if (fall) begin
                    sck_nxt = 1'b0;
                    if (last) begin
                        // eighth falling edge ends the byte
                        rx_nxt = shift_r;
                        busy_nxt = 1'b0;
                        state_nxt = ST_IDLE;
                    end else begin
                        mosi_nxt = shift_r[7];
                        bits_nxt = bits_r + 4'h1;
                    end
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end
    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            state_r <= ST_IDLE;
            txbuf_r <= `SMM_RST_BYTE;
            o_tx_buf_full <= 1'b0;
            shift_r <= `SMM_RST_BYTE;
            bits_r <= 4'h0;
            o_rx_data <= `SMM_RST_BYTE;
            o_busy <= 1'b0;
            o_sck <= 1'b0;
            o_mosi <= 1'b0;
        end else begin
            state_r <= state_nxt;
            txbuf_r <= txbuf_nxt;
            o_tx_buf_full <= buf_full_nxt;
            shift_r <= shift_nxt;
            bits_r <= bits_nxt;
            o_rx_data <= rx_nxt;
            o_busy <= busy_nxt;
            o_sck <= sck_nxt;
            o_mosi <= mosi_nxt;
        end
    end

    //----------------------------------------
    // pin enables and select output
    //----------------------------------------
    always @* begin
        sck_oe_nxt = enabled && !fault;
        mosi_oe_nxt = enabled && !fault;
        // select driven only in 4-wire mode; 3-wire leaves the pin unused
        ss_nxt = sel_hi_r ? sel_lo_r : 1'b1;
        ss_oe_nxt = sel_hi_r && o_port_enable_bit;
    end
    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_sck_oe <= 1'b0;
            o_mosi_oe <= 1'b0;
            o_ss <= 1'b1;
            o_ss_oe <= 1'b0;
        end else begin
            o_sck_oe <= sck_oe_nxt;
            o_mosi_oe <= mosi_oe_nxt;
            o_ss <= ss_nxt;
            o_ss_oe <= ss_oe_nxt;
        end
    end
endmodule

// file: hw/smm_defines.vh
`ifndef SMM_DEFINES_VH
`define SMM_DEFINES_VH
// control bit positions of the serial control word
`define SMM_CTL_PORT_EN 0
`define SMM_CTL_SEL_LO 2
`define SMM_CTL_SEL_HI 3
`define SMM_CTL_MODE_FAULT 5
`define SMM_CTL_MASTER_EN 6
`define SMM_CTL_DONE 7
// reset values
`define SMM_RST_SEL_HI 1'b0
`define SMM_RST_SEL_LO 1'b1
`define SMM_RST_BYTE 8'h00
// sck half period in system clocks
`define SMM_HALF_PERIOD 4
`define SMM_BITS_PER_BYTE 8
`endif

// file: hw/smm_sync.v
module smm_sync (
    // clock and reset
    input wire i_ref_clk,
    input wire i_reset,
    // async level in, synchronised level out
    input wire i_async,
    output wire o_sync
);
    reg meta_r;
    reg sync_r;
    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end
    assign o_sync = sync_r;
endmodule

// file: hw/smm_clkgen.v
`include "smm_defines.vh"
module smm_clkgen #(
    parameter HALF = `SMM_HALF_PERIOD
) (
    // clock and reset
    input wire i_ref_clk,
    input wire i_reset,
    // run request and edge strobes
    input wire i_run,
    output reg o_rise,
    output reg o_fall
);
    reg [7:0] cnt_r;
    reg phase_r;
    always @(posedge i_ref_clk) begin
        if (i_reset || !i_run) begin
            cnt_r <= 8'h00;
            phase_r <= 1'b0;
            o_rise <= 1'b0;
            o_fall <= 1'b0;
        end else if (cnt_r == HALF - 1) begin
            cnt_r <= 8'h00;
            phase_r <= ~phase_r;
            o_rise <= ~phase_r;
            o_fall <= phase_r;
        end else begin
            cnt_r <= cnt_r + 8'h01;
            o_rise <= 1'b0;
            o_fall <= 1'b0;
        end
    end
endmodule

// file: test/smm_chk.sv
module smm_chk (
    input wire logic i_ref_clk, i_reset, i_ctl_we, i_data_we, i_done_clr,
    input wire logic o_master_enable_flag, o_port_enable_bit, o_transfer_done_flag,
    input wire logic o_mode_fault_flag, o_tx_buf_full, o_busy, o_irq, o_sck, o_sck_oe,
    input wire logic o_mosi_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] n_r;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    // sck rises seen in the current byte
    always @(posedge i_ref_clk) begin
        if (i_reset || !o_busy || $rose(o_transfer_done_flag))
            n_r <= 4'h0;
        else if ($rose(o_sck))
            n_r <= n_r + 4'h1;
    end
    property p_start;
        i_data_we && o_master_enable_flag && o_port_enable_bit && !o_busy && !o_tx_buf_full
            |=> o_tx_buf_full ##1 o_busy;
    endproperty
    a_start: assert property (p_start) else $error("no start");
    property p_eight;
        $rose(o_transfer_done_flag) |-> n_r == 4'h8 && $past(o_busy);
    endproperty
    a_eight: assert property (p_eight) else $error("sck count");
    property p_done;
        o_transfer_done_flag && !i_done_clr |=> o_transfer_done_flag;
    endproperty
    a_done: assert property (p_done) else $error("done lost");
    property p_irq;
        o_irq |-> (o_transfer_done_flag || o_mode_fault_flag) ##1 !o_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq");
    property p_idle;
        !o_busy |-> !o_sck;
    endproperty
    a_idle: assert property (p_idle) else $error("sck idle");
    property p_fault;
        $rose(o_mode_fault_flag) |-> !o_master_enable_flag && !o_port_enable_bit;
    endproperty
    a_fault: assert property (p_fault) else $error("fault");
    property p_abort;
        o_mode_fault_flag && !o_master_enable_flag |=> !o_busy && !o_sck_oe && !o_mosi_oe;
    endproperty
    a_abort: assert property (p_abort) else $error("abort");
    property p_stay;
        !o_master_enable_flag && !i_ctl_we |=> !o_master_enable_flag;
    endproperty
    a_stay: assert property (p_stay) else $error("re-enabled");
endmodule

// file: test/smm_slave.sv
module smm_slave (
    input wire logic i_sck, i_mosi, i_load,
    input wire logic [7:0] i_byte,
    output logic o_miso,
    output logic [7:0] o_got
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sh_r = 8'h00;
    // msb first on each fall; changing filler once the byte is out
    always @(posedge i_load or negedge i_sck) begin
        if (i_load)
            sh_r <= i_byte;
        else
            sh_r <= {sh_r[6:0], ~sh_r[0]};
    end
    always @(posedge i_sck) o_got <= {o_got[6:0], i_mosi};
    assign o_miso = sh_r[7];
endmodule

// file: test/smm_master_test.sv
module smm_master_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_ref_clk = 1'b0, i_reset = 1'b1, i_ctl_we = 1'b0, i_master_enable = 1'b0;
    logic i_port_enable = 1'b0, i_select_mode_high = 1'b0, i_select_mode_low = 1'b1;
    logic i_intr_enable = 1'b0, i_done_clr = 1'b0, i_fault_clr = 1'b0, i_data_we = 1'b0;
    logic i_ss = 1'b1, ld = 1'b0;
    logic [7:0] i_data = 8'h00, sb = 8'h00, got, o_rx_data;
    logic o_master_enable_flag, o_port_enable_bit, o_transfer_done_flag, o_mode_fault_flag;
    logic o_tx_buf_full, o_busy, o_irq, o_sck, o_sck_oe, o_mosi, o_mosi_oe, o_ss, o_ss_oe;
    wire i_miso;
    int fails = 0, n_compared = 0;
    smm_master u_smm_master (.*);
    smm_slave u_smm_slave (.i_sck(o_sck), .i_mosi(o_mosi), .i_load(ld), .i_byte(sb),
        .o_miso(i_miso), .o_got(got));
    always #20 i_ref_clk = ~i_ref_clk;
    task step(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask
    task chk(input logic c, input string m);
        n_compared++;
        if (c !== 1'b1) begin
            fails++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task conclude;
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task ctl(input logic me, pe, hi, lo);
        step(1);
        {i_master_enable, i_port_enable, i_select_mode_high, i_select_mode_low} = {me, pe, hi, lo};
        i_intr_enable = 1'b1;
        i_ctl_we = 1'b1;
        step(1);
        i_ctl_we = 1'b0;
        step(3);
    endtask
    task put(input logic [7:0] d);
        step(1);
        i_data = d;
        i_data_we = 1'b1;
        step(1);
        i_data_we = 1'b0;
    endtask
    task wdone;
        int k;
        k = 0;
        while (o_transfer_done_flag !== 1'b1 && k < 400) begin
            step(1);
            k++;
        end
        chk(k < 400, "no done");
        if (k >= 400)
            conclude();
        chk(o_irq === 1'b1, "no irq");
        step(1);
        i_done_clr = 1'b1;
        step(1);
        i_done_clr = 1'b0;
    endtask
    task xfer(input logic [7:0] d, s);
        step(1);
        sb = s;
        ld = 1'b1;
        step(1);
        ld = 1'b0;
        put(d);
        wdone();
        chk(o_rx_data === s, "rx byte");
        chk(got === d, "tx byte");
    endtask
    // ----------------
    // scenarios
    // ----------------
    initial begin
        step(10);
        i_reset = 1'b0;
        step(1);
        chk(o_ss_oe === 1'b0 && o_ss === 1'b1, "reset select");
        ctl(1'b0, 1'b1, 1'b1, 1'b0);
        chk(o_ss_oe === 1'b1 && o_ss === 1'b0, "select low");
        ctl(1'b0, 1'b1, 1'b1, 1'b1);
        chk(o_ss === 1'b1, "select high");
        ctl(1'b0, 1'b1, 1'b0, 1'b0);
        chk(o_ss_oe === 1'b0, "three wire");
        put(8'h5a);
        step(4);
        chk(o_busy === 1'b0 && o_sck === 1'b0, "disabled");
        ctl(1'b1, 1'b1, 1'b0, 1'b0);
        xfer(8'ha5, 8'h3c);
        xfer(8'h01, 8'h80);
        put(8'h96);
        put(8'h69);
        wdone();
        wdone();
        chk(got === 8'h69, "second byte");
        ctl(1'b1, 1'b1, 1'b0, 1'b1);
        put(8'hff);
        step(20);
        i_ss = 1'b0;
        step(3);
        chk(o_irq === 1'b1, "fault irq");
        step(3);
        chk({o_mode_fault_flag, o_master_enable_flag, o_port_enable_bit} === 3'b100, "fault");
        chk({o_busy, o_sck_oe, o_transfer_done_flag} === 3'b000, "abort");
        i_ss = 1'b1;
        put(8'h11);
        step(4);
        chk({o_busy, o_master_enable_flag} === 2'b00, "stay off");
        i_fault_clr = 1'b1;
        step(1);
        i_fault_clr = 1'b0;
        ctl(1'b1, 1'b1, 1'b0, 1'b1);
        xfer(8'hc3, 8'h5e);
        conclude();
    end
endmodule
bind smm_master smm_chk u_smm_chk (.*);
